// ### design/fgp_pkg.sv
// package: constants, selects and carriers of the fast gpio port
package fgp_pkg;
  localparam int PORT_W = 32;
  localparam int NPORT = 2;
  localparam int IRQ_PINS = 42;
  localparam int ADDR_W = 8;
  localparam int IRQ_W0_DEF = 28;
  localparam int IRQ_W1_DEF = 14;
  // port page: paddr[7:6] == 0, port = paddr[5]
  localparam logic [1:0] PORT_PAGE = 2'h0;
  localparam logic [4:0] OFS_DIR = 5'h00;
  localparam logic [4:0] OFS_MASK = 5'h04;
  localparam logic [4:0] OFS_PIN = 5'h08;
  localparam logic [4:0] OFS_SET = 5'h0c;
  localparam logic [4:0] OFS_CLR = 5'h10;
  // edge page: paddr[7:5] == 2, port = paddr[4]
  localparam logic [2:0] IRQ_PAGE = 3'h2;
  localparam logic [3:0] OFS_RISE = 4'h0;
  localparam logic [3:0] OFS_FALL = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_IMSK = 4'hc;
  // reset values
  localparam logic [31:0] RST_DIR = 32'h0000_0000;
  localparam logic [31:0] RST_OUT = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_EN = 32'h0000_0000;
  localparam logic [31:0] RST_STAT = 32'h0000_0000;
  localparam logic [31:0] RST_OEN = 32'hffff_ffff;

  typedef logic [PORT_W-1:0] fgp_word_t;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_DIR, SEL_MASK, SEL_PIN, SEL_SET, SEL_CLR,
    SEL_RISE, SEL_FALL, SEL_STAT, SEL_IMSK
  } fgp_sel_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } fgp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fgp_apb_rsp_t;
endpackage

// ### design/fgp_pin_sync.sv
// module: two-flop level synchroniser for pin inputs
`timescale 1ns/10ps
module fgp_pin_sync #(
  parameter int W = 64
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pinRaw,
  output logic [W-1:0] pinLevel
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  if (W < 1) begin : g_bad
    $error("fgp_pin_sync: W must be at least 1");
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= pinRaw;
      stage2 <= stage1;
    end
  end

  assign pinLevel = stage2;
endmodule

// ### design/fgp_edge_cap.sv
// module: clockless pin edge capture handed over to the system clock
`timescale 1ns/10ps
module fgp_edge_cap #(
  parameter int W = 28
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pinRaw,
  output logic [W-1:0] rose,
  output logic [W-1:0] fell
);
  logic [W-1:0] riseTog;
  logic [W-1:0] fallTog;
  logic [W-1:0] riseS1, riseS2, riseS3;
  logic [W-1:0] fallS1, fallS2, fallS3;

  if (W < 1 || W > 32) begin : g_bad
    $error("fgp_edge_cap: W must be 1 to 32");
  end

  for (genvar i = 0; i < W; i++) begin : g_pin
    logic rT;
    logic fT;
    // pin edge toggles with no clock
    always_ff @(posedge pinRaw[i] or negedge rst_n) begin
      if (!rst_n) begin
        rT <= 1'b0;
      end else begin
        rT <= ~rT;
      end
    end
    always_ff @(negedge pinRaw[i] or negedge rst_n) begin
      if (!rst_n) begin
        fT <= 1'b0;
      end else begin
        fT <= ~fT;
      end
    end
    assign riseTog[i] = rT;
    assign fallTog[i] = fT;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      riseS1 <= '0;
      riseS2 <= '0;
      riseS3 <= '0;
      fallS1 <= '0;
      fallS2 <= '0;
      fallS3 <= '0;
    end else begin
      riseS1 <= riseTog;
      riseS2 <= riseS1;
      riseS3 <= riseS2;
      fallS1 <= fallTog;
      fallS2 <= fallS1;
      fallS3 <= fallS2;
    end
  end

  assign rose = riseS2 ^ riseS3;
  assign fell = fallS2 ^ fallS3;
endmodule

// ### design/fast_gpio_port.sv
// module: fast gpio port with apb registers and edge interrupts
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - a pin not claimed by a peripheral is driven or sampled by the port, direction chosen per bit at any time.
// - separate set and clear writes force chosen output bits high or low and leave the rest alone.
// - reads give the stored output value and, at another address, the sampled pin levels.
// - the mask keeps masked bits out of pin-level reads and leaves them unchanged by pin, set and clear writes.
// - every register takes byte, half-word and word accesses, touching only the addressed lanes.
// - one bus write can replace the whole output value of a port.
// - after reset every pin is an input.
// - each interrupt-capable pin, 42 in all, flags a rising, a falling or either edge as programmed.
// - edge capture works without the clock running, as in power-down.
// - any enabled edge event raises wakeReq, which is registered on sys_clk and so appears only once the clock runs.
// - the registers sit on a fast bus path and answer with the least latency.
module fast_gpio_port #(
  parameter int IRQ_W0 = fgp_pkg::IRQ_W0_DEF,
  parameter int IRQ_W1 = fgp_pkg::IRQ_W1_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input fgp_pkg::fgp_apb_req_t apbReq,
  output fgp_pkg::fgp_apb_rsp_t apbRsp,
  input wire logic [fgp_pkg::NPORT-1:0][fgp_pkg::PORT_W-1:0] pinIn,
  input wire logic [fgp_pkg::NPORT-1:0][fgp_pkg::PORT_W-1:0] funcSel,
  output logic [fgp_pkg::NPORT-1:0][fgp_pkg::PORT_W-1:0] pinOut,
  output logic [fgp_pkg::NPORT-1:0][fgp_pkg::PORT_W-1:0] pinOeN,
  output logic irq,
  output logic wakeReq
);
  import fgp_pkg::*;

  if (IRQ_W0 + IRQ_W1 != IRQ_PINS || IRQ_W0 > PORT_W || IRQ_W1 > PORT_W || IRQ_W0 < 1 || IRQ_W1 < 1) begin : g_bad
    $error("fast_gpio_port: edge pin widths must be 1..32 and sum to 42");
  end

  // byte strobes to a bit mask
  function automatic fgp_word_t lanes(input logic [3:0] be);
    fgp_word_t m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  // write data into the addressed lanes only
  function automatic fgp_word_t wmerge(input fgp_word_t old, input fgp_word_t wd, input logic [3:0] be);
    fgp_word_t lm;
    lm = lanes(be);
    return (old & ~lm) | (wd & lm);
  endfunction

  fgp_word_t [NPORT-1:0] pinLevel;
  fgp_word_t [NPORT-1:0] rose, fell;
  logic [IRQ_W0-1:0] rose0, fell0;
  logic [IRQ_W1-1:0] rose1, fell1;
  fgp_word_t [NPORT-1:0] dirReg, next_dirReg;
  fgp_word_t [NPORT-1:0] outReg, next_outReg;
  fgp_word_t [NPORT-1:0] maskReg, next_maskReg;
  fgp_word_t [NPORT-1:0] riseEn, next_riseEn;
  fgp_word_t [NPORT-1:0] fallEn, next_fallEn;
  fgp_word_t [NPORT-1:0] stat, next_stat;
  fgp_word_t [NPORT-1:0] imsk, next_imsk;
  fgp_word_t [NPORT-1:0] statClr;
  fgp_word_t [NPORT-1:0] next_pinOeN;
  fgp_apb_rsp_t next_apbRsp;
  logic next_irq;
  logic next_wakeReq;
  fgp_sel_t sel;
  logic port;
  logic setup;
  logic wrEn;
  fgp_word_t lm;
  fgp_word_t merged;

  // pin levels pass two flops before use
  fgp_pin_sync #(.W(NPORT*PORT_W)) uSync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pinRaw(pinIn),
    .pinLevel(pinLevel)
  );

  fgp_edge_cap #(.W(IRQ_W0)) uEdge0 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pinRaw(pinIn[0][IRQ_W0-1:0]),
    .rose(rose0),
    .fell(fell0)
  );

  fgp_edge_cap #(.W(IRQ_W1)) uEdge1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pinRaw(pinIn[1][IRQ_W1-1:0]),
    .rose(rose1),
    .fell(fell1)
  );

  // edge pulses widened to full ports
  always_comb begin
    rose = '0;
    fell = '0;
    rose[0][IRQ_W0-1:0] = rose0;
    fell[0][IRQ_W0-1:0] = fell0;
    rose[1][IRQ_W1-1:0] = rose1;
    fell[1][IRQ_W1-1:0] = fell1;
  end

  // address decode
  always_comb begin
    sel = SEL_NONE;
    port = 1'b0;
    if (apbReq.paddr[7:6] == PORT_PAGE) begin
      port = apbReq.paddr[5];
      unique case (apbReq.paddr[4:0])
        OFS_DIR: sel = SEL_DIR;
        OFS_MASK: sel = SEL_MASK;
        OFS_PIN: sel = SEL_PIN;
        OFS_SET: sel = SEL_SET;
        OFS_CLR: sel = SEL_CLR;
        default: sel = SEL_NONE;
      endcase
    end else if (apbReq.paddr[7:5] == IRQ_PAGE) begin
      port = apbReq.paddr[4];
      unique case (apbReq.paddr[3:0])
        OFS_RISE: sel = SEL_RISE;
        OFS_FALL: sel = SEL_FALL;
        OFS_STAT: sel = SEL_STAT;
        OFS_IMSK: sel = SEL_IMSK;
        default: sel = SEL_NONE;
      endcase
    end
  end

  assign setup = apbReq.psel & ~apbReq.penable;
  assign wrEn = apbReq.psel & apbReq.penable & apbRsp.pready & apbReq.pwrite;
  assign lm = lanes(apbReq.pstrb);
  assign merged = wmerge(outReg[port], apbReq.pwdata, apbReq.pstrb);

  // register writes
  always_comb begin
    next_dirReg = dirReg;
    next_outReg = outReg;
    next_maskReg = maskReg;
    next_riseEn = riseEn;
    next_fallEn = fallEn;
    next_imsk = imsk;
    statClr = '0;
    if (wrEn) begin
      unique case (sel)
        SEL_DIR: next_dirReg[port] = wmerge(dirReg[port], apbReq.pwdata, apbReq.pstrb);
        SEL_MASK: next_maskReg[port] = wmerge(maskReg[port], apbReq.pwdata, apbReq.pstrb);
        // whole port in one write, masked bits held
        SEL_PIN: next_outReg[port] = (merged & ~maskReg[port]) | (outReg[port] & maskReg[port]);
        SEL_SET: next_outReg[port] = outReg[port] | (apbReq.pwdata & lm & ~maskReg[port]);
        SEL_CLR: next_outReg[port] = outReg[port] & ~(apbReq.pwdata & lm & ~maskReg[port]);
        // per pin rising or falling choice
        SEL_RISE: next_riseEn[port] = wmerge(riseEn[port], apbReq.pwdata, apbReq.pstrb);
        SEL_FALL: next_fallEn[port] = wmerge(fallEn[port], apbReq.pwdata, apbReq.pstrb);
        SEL_STAT: statClr[port] = apbReq.pwdata & lm;
        SEL_IMSK: next_imsk[port] = wmerge(imsk[port], apbReq.pwdata, apbReq.pstrb);
        SEL_NONE: next_dirReg = dirReg;
      endcase
    end
  end

  // sticky flags, a new edge beats a clear
  always_comb begin
    next_stat = (stat & ~statClr) | (rose & riseEn) | (fell & fallEn);
    next_irq = |(next_stat & next_imsk);
    // any enabled captured edge requests wake
    next_wakeReq = |next_stat;
    next_pinOeN = ~(next_dirReg & ~funcSel);
  end

  always_comb begin
    next_apbRsp = '0;
    next_apbRsp.pready = setup;
    if (setup && !apbReq.pwrite) begin
      unique case (sel)
        SEL_DIR: next_apbRsp.prdata = dirReg[port];
        SEL_MASK: next_apbRsp.prdata = maskReg[port];
        SEL_PIN: next_apbRsp.prdata = pinLevel[port] & ~maskReg[port];
        SEL_SET: next_apbRsp.prdata = outReg[port];
        SEL_CLR: next_apbRsp.prdata = '0;
        SEL_RISE: next_apbRsp.prdata = riseEn[port];
        SEL_FALL: next_apbRsp.prdata = fallEn[port];
        SEL_STAT: next_apbRsp.prdata = stat[port];
        SEL_IMSK: next_apbRsp.prdata = imsk[port];
        SEL_NONE: next_apbRsp.pslverr = 1'b1;
      endcase
    end else if (setup && sel == SEL_NONE) begin
      next_apbRsp.pslverr = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dirReg <= {NPORT{RST_DIR}};
      outReg <= {NPORT{RST_OUT}};
      maskReg <= {NPORT{RST_MASK}};
      riseEn <= {NPORT{RST_EN}};
      fallEn <= {NPORT{RST_EN}};
      stat <= {NPORT{RST_STAT}};
      imsk <= {NPORT{RST_EN}};
      pinOeN <= {NPORT{RST_OEN}};
      apbRsp <= '0;
      irq <= 1'b0;
      wakeReq <= 1'b0;
    end else begin
      dirReg <= next_dirReg;
      outReg <= next_outReg;
      maskReg <= next_maskReg;
      riseEn <= next_riseEn;
      fallEn <= next_fallEn;
      stat <= next_stat;
      imsk <= next_imsk;
      pinOeN <= next_pinOeN;
      apbRsp <= next_apbRsp;
      irq <= next_irq;
      wakeReq <= next_wakeReq;
    end
  end

  assign pinOut = outReg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_RESET_INPUTS: assert property ($past(!rst_n) |-> pinOeN == {NPORT{RST_OEN}})
    else $error("pins not all inputs after reset");

  AST_DIR_DRIVE: assert property (
    (wrEn && sel == SEL_DIR && apbReq.pstrb == 4'hf)
    |=> pinOeN[$past(port)] == ~($past(apbReq.pwdata) & ~$past(funcSel[port])))
    else $error("direction write not seen on output enables");

  AST_SET_ONLY: assert property ((wrEn && sel == SEL_SET) |=>
    ((~outReg[$past(port)] & $past(outReg[port])) == '0))
    else $error("set write cleared a bit");

  AST_CLR_ONLY: assert property ((wrEn && sel == SEL_CLR) |=>
    ((outReg[$past(port)] & ~$past(outReg[port])) == '0))
    else $error("clear write set a bit");

  AST_PIN_READ: assert property ((setup && !apbReq.pwrite && sel == SEL_PIN) |=>
    apbRsp.prdata == $past(pinLevel[port] & ~maskReg[port]))
    else $error("pin read does not show masked levels");

  AST_MASK_KEEP: assert property ((wrEn && sel == SEL_PIN) |=>
    (((outReg[$past(port)] ^ $past(outReg[port])) & $past(maskReg[port])) == '0))
    else $error("masked output bit changed");

  AST_LANES: assert property ((wrEn && sel == SEL_DIR) |=>
    (((dirReg[$past(port)] ^ $past(dirReg[port])) & ~$past(lm)) == '0))
    else $error("write touched an unaddressed lane");

  AST_FULL_WRITE: assert property (
    (wrEn && sel == SEL_PIN && apbReq.pstrb == 4'hf && maskReg[port] == '0)
    |=> outReg[$past(port)] == $past(apbReq.pwdata))
    else $error("full port write not applied");

  AST_EDGE_FLAG: assert property ((rose[0][0] && riseEn[0][0]) |=> stat[0][0])
    else $error("enabled rising edge did not set its flag");

  AST_STICKY: assert property (
    (stat[1][0] && !(wrEn && sel == SEL_STAT && port && apbReq.pwdata[0] && apbReq.pstrb[0]))
    |=> stat[1][0])
    else $error("flag dropped without a clear");

  AST_IRQ: assert property ($rose(|(stat & imsk)) |-> irq)
    else $error("interrupt not raised with unmasked flag");

  AST_WAKE: assert property ($rose(|stat) |-> wakeReq)
    else $error("wake request missing for captured edge");

  AST_ZERO_WAIT: assert property (setup |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("access not answered in the first access cycle");

  AST_SET_APPLY: assert property (
    (wrEn && sel == SEL_SET && apbReq.pstrb == 4'hf && maskReg[port] == '0)
    |=> (outReg[$past(port)] & $past(apbReq.pwdata)) == $past(apbReq.pwdata))
    else $error("set write missed a bit");

  AST_CLR_APPLY: assert property (
    (wrEn && sel == SEL_CLR && apbReq.pstrb == 4'hf && maskReg[port] == '0)
    |=> (outReg[$past(port)] & $past(apbReq.pwdata)) == '0)
    else $error("clear write missed a bit");

  AST_OUT_READ: assert property ((setup && !apbReq.pwrite && sel == SEL_SET) |=>
    apbRsp.prdata == $past(outReg[port]))
    else $error("output register readback wrong");

  AST_MASK_READ: assert property ((setup && !apbReq.pwrite && sel == SEL_PIN) |=>
    (apbRsp.prdata & $past(maskReg[port])) == '0)
    else $error("masked pin bit read as one");

  AST_SET_MASKED: assert property ((wrEn && (sel == SEL_SET || sel == SEL_CLR)) |=>
    (((outReg[$past(port)] ^ $past(outReg[port])) & $past(maskReg[port])) == '0))
    else $error("set or clear changed a masked bit");

  AST_PIN_LANES: assert property ((wrEn && sel == SEL_PIN) |=>
    (((outReg[$past(port)] ^ $past(outReg[port])) & ~$past(lm)) == '0))
    else $error("port write touched an unaddressed lane");

  AST_FALL_FLAG: assert property ((fell[1][0] && fallEn[1][0]) |=> stat[1][0])
    else $error("enabled falling edge did not set its flag");

  AST_NO_FLAG: assert property (
    (!stat[0][0] && !(rose[0][0] && riseEn[0][0]) && !(fell[0][0] && fallEn[0][0]))
    |=> !stat[0][0])
    else $error("flag set without an enabled edge");

  AST_CLAIMED_FREE: assert property (1'b1 |=> (~pinOeN & $past(funcSel)) == '0)
    else $error("pin claimed by a peripheral is driven");

  AST_DIR_READ: assert property ((setup && !apbReq.pwrite && sel == SEL_DIR) |=>
    apbRsp.prdata == $past(dirReg[port]))
    else $error("direction readback wrong");

  AST_STAT_CLEAR: assert property (
    (wrEn && sel == SEL_STAT && !port && apbReq.pwdata[0] && apbReq.pstrb[0] && !rose[0][0] && !fell[0][0])
    |=> !stat[0][0])
    else $error("write of one did not clear the flag");

  AST_IRQ_LEVEL: assert property (irq == |(stat & imsk))
    else $error("interrupt does not follow unmasked flags");

  AST_WAKE_LEVEL: assert property (wakeReq == |stat)
    else $error("wake request does not follow captured flags");

  AST_BAD_ADDR: assert property ((setup && sel == SEL_NONE) |=>
    (apbRsp.pslverr && apbRsp.prdata == '0))
    else $error("unmapped access not refused");

  COV_SET_WRITE: cover property (wrEn && sel == SEL_SET);
  COV_FALL_FLAG: cover property ((fell[0] & fallEn[0]) != '0 ##1 stat[0] != '0);
  COV_IRQ: cover property ($rose(irq));
  COV_BAD_ADDR: cover property (apbRsp.pslverr && apbRsp.pready);
  COV_BOTH_EDGES: cover property (riseEn[0][0] && fallEn[0][0] && fell[0][0] ##1 stat[0][0]);
endmodule

// ### testbench/fgp_pin_model.sv
// partner model: pad level seen by the port from gpio drive and board drive
`timescale 1ns/10ps
module fgp_pin_model (
  input wire logic [fgp_pkg::NPORT-1:0][fgp_pkg::PORT_W-1:0] pinOut,
  input wire logic [fgp_pkg::NPORT-1:0][fgp_pkg::PORT_W-1:0] pinOeN,
  input wire logic [fgp_pkg::NPORT-1:0][fgp_pkg::PORT_W-1:0] extDrive,
  output logic [fgp_pkg::NPORT-1:0][fgp_pkg::PORT_W-1:0] pinIn
);
  import fgp_pkg::*;
  assign pinIn = (pinOut & ~pinOeN) | (extDrive & pinOeN);
endmodule

// ### testbench/test_fast_gpio_port.sv
// testbench: register, pin and edge interrupt scenarios of the fast gpio port
`timescale 1ns/10ps
module test_fast_gpio_port;
  import fgp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  fgp_apb_req_t apbReq = '0;
  fgp_apb_rsp_t apbRsp;
  logic [1:0][31:0] pinIn;
  logic [1:0][31:0] funcSel = {32'h0, 32'h1};
  logic [1:0][31:0] pinOut;
  logic [1:0][31:0] pinOeN;
  logic [1:0][31:0] extDrive = {32'h1, 32'h0};
  logic irq;
  logic wakeReq;
  logic [31:0] rdata;
  logic err;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  fast_gpio_port #(.IRQ_W0(28), .IRQ_W1(14)) i_fast_gpio_port (.sys_clk(sys_clk), .rst_n(rst_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .pinIn(pinIn), .funcSel(funcSel), .pinOut(pinOut),
    .pinOeN(pinOeN), .irq(irq), .wakeReq(wakeReq));
  fgp_pin_model i_fgp_pin_model (.pinOut(pinOut), .pinOeN(pinOeN), .extDrive(extDrive), .pinIn(pinIn));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    forever begin
      @(posedge sys_clk);
      cycles++;
      if (cycles == 5000) begin
        num_errors++;
        report_and_stop();
      end
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (apbRsp.pready !== 1'b1);
    rdata = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdata, e);
  endtask

  task test_reset;
    chk(pinOeN[0], 32'hffff_ffff);
    chk(pinOeN[1], 32'hffff_ffff);
    chk({30'h0, irq, wakeReq}, 32'h0);
    $display("test reset done");
  endtask

  task test_output;
    wr(8'h00, 32'hffff_ffff);
    @(negedge sys_clk);
    chk(pinOeN[0], 32'h0000_0001);
    rd(8'h00, 32'hffff_ffff);
    @(posedge sys_clk);
    funcSel[0] <= 32'h0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(pinOeN[0], 32'h0);
    @(posedge sys_clk);
    funcSel[0] <= 32'h1;
    wr(8'h08, 32'h1234_5678);
    @(negedge sys_clk);
    chk(pinOut[0], 32'h1234_5678);
    wr(8'h0c, 32'h0000_00f0);
    @(negedge sys_clk);
    chk(pinOut[0], 32'h1234_56f8);
    wr(8'h10, 32'h1200_0000);
    @(negedge sys_clk);
    chk(pinOut[0], 32'h0034_56f8);
    rd(8'h0c, 32'h0034_56f8);
    rd(8'h08, 32'h0034_56f8);
    wr(8'h2c, 32'h0000_0003);
    rd(8'h2c, 32'h0000_0003);
    wr(8'h30, 32'h0000_0001);
    @(negedge sys_clk);
    chk(pinOut[1], 32'h0000_0002);
    apb(1'b1, 8'h08, 32'h00ab_0000, 4'h4);
    @(negedge sys_clk);
    chk(pinOut[0], 32'h00ab_56f8);
    wr(8'h04, 32'h0000_ffff);
    wr(8'h08, 32'hffff_ffff);
    @(negedge sys_clk);
    chk(pinOut[0], 32'hffff_56f8);
    repeat (3) @(posedge sys_clk);
    rd(8'h08, 32'hffff_0000);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0);
    @(negedge sys_clk);
    chk(pinOeN[0], 32'hffff_ffff);
    apb(1'b0, 8'h3c, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1);
    $display("test output done");
  endtask

  task test_edges;
    int n;
    n = 0;
    wr(8'h40, 32'h1);
    wr(8'h4c, 32'h1);
    wr(8'h54, 32'h1);
    extDrive[0][0] <= 1'b1;
    while (irq !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, wakeReq}, 32'h1);
    rd(8'h48, 32'h1);
    wr(8'h48, 32'h1);
    repeat (3) @(negedge sys_clk);
    chk({30'h0, irq, wakeReq}, 32'h0);
    @(posedge sys_clk);
    extDrive[0][0] <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(8'h48, 32'h0);
    extDrive[1][0] <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(8'h58, 32'h1);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, wakeReq}, 32'h1);
    wr(8'h58, 32'h1);
    repeat (3) @(negedge sys_clk);
    chk({31'h0, wakeReq}, 32'h0);
    wr(8'h44, 32'h1);
    extDrive[0][0] <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd(8'h48, 32'h1);
    wr(8'h48, 32'h1);
    extDrive[0][0] <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(8'h48, 32'h1);
    wr(8'h48, 32'h1);
    repeat (3) @(negedge sys_clk);
    chk({30'h0, irq, wakeReq}, 32'h0);
    $display("test edges done");
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    test_reset();
    test_output();
    test_edges();
    report_and_stop();
  end
endmodule
